// File: bench/core_model.sv
// Core and program memory model facing the interrupt unit.
// Assumes the save and vector read handshake; slow_i adds wait cycles.
`timescale 1ns/10ps
`default_nettype none
module core_model (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic save_state_i,
  input wire logic pmem_rd_i,
  input wire logic [15:0] pmem_addr_i,
  output logic save_done_o,
  output logic [7:0] pmem_data_o,
  output logic pmem_valid_o
);
  ////////////////////////////////////////////////////////////////////////
  // Vector table content: byte at address a holds 8'h10 plus a
  function automatic logic [7:0] vec_byte(input logic [15:0] a);
    return 8'h10 + a[7:0];
  endfunction : vec_byte

  // Answer saves and byte reads; data is scrambled once valid drops
  initial begin
    save_done_o = 1'b0;
    pmem_valid_o = 1'b0;
    pmem_data_o = 8'h5a;
    forever begin
      @(posedge clk_i);
      if (save_state_i === 1'b1) begin
        repeat (slow_i ? 3 : 0) @(posedge clk_i);
        save_done_o <= 1'b1;
        @(posedge clk_i);
        save_done_o <= 1'b0;
      end else if (pmem_rd_i === 1'b1) begin
        repeat (slow_i ? 2 : 0) @(posedge clk_i);
        pmem_valid_o <= 1'b1;
        pmem_data_o <= vec_byte(pmem_addr_i);
        @(posedge clk_i);
        pmem_valid_o <= 1'b0;
        pmem_data_o <= ~pmem_data_o;
      end
    end
  end
endmodule : core_model
`default_nettype wire

// File: bench/irq_vector_unit_tb.sv
// Self-checking bench for the interrupt unit.
// Assumes the core model answers the grant handshake.
`timescale 1ns/10ps
`default_nettype none
module irq_vector_unit_tb;
  import irq_unit_pkg::*;
  logic clk_i, reset_i, slow, line_one, line_two, line_three, tmr0, tmr1, en;
  logic [3:0] strb;
  logic save_done, pmem_valid, save_state, pmem_rd, handler_load;
  logic [7:0] pmem_data;
  logic [15:0] pmem_addr, handler_addr;
  logic [2:0] grant_slot;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int n_fail, n_tests;

  ////////////////////////////////////////////////////////////////////////
  // Design and core model
  irq_vector_unit dut (.clk_i(clk_i), .reset_i(reset_i), .enable_i(en),
    .port3_line_one_i(line_one), .port3_line_two_i(line_two), .port3_line_three_i(line_three),
    .timer_zero_event_i(tmr0), .timer_one_event_i(tmr1), .save_state_o(save_state),
    .save_done_i(save_done), .pmem_rd_o(pmem_rd), .pmem_addr_o(pmem_addr), .pmem_data_i(pmem_data),
    .pmem_valid_i(pmem_valid), .handler_load_o(handler_load), .handler_addr_o(handler_addr),
    .grant_slot_o(grant_slot), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(strb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
  core_model core (.clk_i(clk_i), .slow_i(slow), .save_state_i(save_state), .pmem_rd_i(pmem_rd),
    .pmem_addr_i(pmem_addr), .save_done_o(save_done), .pmem_data_o(pmem_data), .pmem_valid_o(pmem_valid));

  // 100 ns clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // Bus write; waits for the response
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    chk("write response", {30'h0, RESP_OKAY}, {30'h0, bresp});
  endtask : wr

  // Bus read returning data and response
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask : rd

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(what, exp, d);
    chk("read response", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask : rd_chk

  // Raise the event of one slot; lines one and three also rise
  task automatic fire(input int s);
    @(posedge clk_i);
    case (s)
      0: line_two <= 1'b0;
      1: line_three <= 1'b0;
      2: line_one <= 1'b0;
      3: line_two <= 1'b1;
      4: tmr0 <= 1'b1;
      default: tmr1 <= 1'b1;
    endcase
    @(posedge clk_i);
    tmr0 <= 1'b0;
    tmr1 <= 1'b0;
    line_one <= 1'b1;
    line_three <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask : fire

  // No save request for a while
  task automatic idle_chk();
    logic any;
    any = 1'b0;
    repeat (12) begin
      @(posedge clk_i);
      if (save_state === 1'b1) any = 1'b1;
    end
    chk("no grant", 0, any);
  endtask : idle_chk

  // Follow one grant sequence to the handler load
  task automatic run_grant(input logic [2:0] e);
    logic seen;
    int k;
    seen = 1'b0;
    k = 0;
    while (handler_load !== 1'b1) begin
      @(posedge clk_i);
      if (save_state === 1'b1) seen = 1'b1;
      if (pmem_rd === 1'b1) begin
        chk("saved before fetch", 1, seen);
        chk("vector address", {e, 1'b0} + k, pmem_addr);
        k++;
      end
    end
    chk("grant slot", e, grant_slot);
    chk("handler address", {8'h10 + {e, 1'b0}, 8'h11 + {e, 1'b0}}, handler_addr);
    chk("vector reads", 2, k);
  endtask : run_grant

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 4; i++) rd_chk("reset value", 4'(4 * i), 0);
    rd(4'h6, d, r);
    chk("unmapped response", {30'h0, RESP_SLVERR}, {30'h0, r});
  endtask : t_reset

  task automatic t_poll();
    for (int s = 0; s < 6; s++) begin
      fire(s);
      rd_chk("request flags", OFS_REQ, (32'h2 << s) - 1);
    end
    wr(OFS_REQ, 32'h15);
    rd_chk("flags after clear", OFS_REQ, 32'h2a);
    wr(OFS_REQ, 32'h3f);
    rd_chk("flags cleared", OFS_REQ, 0);
  endtask : t_poll

  // Enable low drops a timer pulse; a write without byte lane 0 changes nothing
  task automatic t_freeze();
    @(posedge clk_i);
    en <= 1'b0;
    tmr0 <= 1'b1;
    @(posedge clk_i);
    tmr0 <= 1'b0;
    @(posedge clk_i);
    en <= 1'b1;
    rd_chk("flags after frozen pulse", OFS_REQ, 0);
    strb <= 4'he;
    wr(OFS_MASK, 32'hff);
    strb <= 4'hf;
    rd_chk("mask after lane 0 off", OFS_MASK, 0);
  endtask : t_freeze

  // Start slot s with slot s masked; a start of 6 wraps to 0
  task automatic t_grant(input int s);
    logic [2:0] e;
    logic [31:0] msk;
    e = (s >= 5) ? 3'h0 : 3'(s + 1);
    msk = 32'h3f & ~(32'h1 << s);
    slow <= s[0];
    for (int k = 0; k < 6; k++) fire(k);
    wr(OFS_PRIO, 32'(s));
    wr(OFS_MASK, msk);
    idle_chk();
    wr(OFS_MASK, msk | 32'h80);
    run_grant(e);
    idle_chk();
    rd_chk("mask after grant", OFS_MASK, msk);
    rd_chk("flags after grant", OFS_REQ, 32'h3f & ~(32'h1 << e));
    rd_chk("status", OFS_STAT, {29'h0, e});
    wr(OFS_REQ, 32'h3f);
  endtask : t_grant

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    n_fail = 0;
    n_tests = 0;
    reset_i = 1'b1;
    slow = 1'b0;
    en = 1'b1;
    strb = 4'hf;
    {line_one, line_two, line_three} = 3'h7;
    {tmr0, tmr1} = 2'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_freeze();
    t_poll();
    for (int s = 0; s < 7; s++) t_grant(s);
    give_verdict();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    $display("MISMATCH watchdog expected finish seen timeout");
    give_verdict();
  end
endmodule : irq_vector_unit_tb
`default_nettype wire

// File: rtl/irq_priority_pick.sv
// Programmable priority encoder: first pending slot at or after a start slot.
// Assumes pending bits are already masked; purely combinational.
`timescale 1ns/10ps
`default_nettype none
module irq_priority_pick (
  input wire logic [5:0] pending_i,
  input wire logic [2:0] start_i,
  output logic found_o,
  output logic [2:0] slot_o
);
  import irq_unit_pkg::*;

  // Scan from the start slot, wrapping; starts above five act as zero
  always_comb begin
    logic [2:0] base;
    logic [2:0] idx;
    base = (start_i > req_slot_f) ? req_slot_a : start_i;
    idx = base;
    found_o = 1'b0;
    slot_o = req_slot_a;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (!found_o && pending_i[idx]) begin
        found_o = 1'b1;
        slot_o = idx;
      end
      idx = (idx == req_slot_f) ? req_slot_a : 3'(idx + 3'h1);
    end
  end
endmodule : irq_priority_pick
`default_nettype wire

// File: rtl/irq_unit_pkg.sv
// Constants, register map and types for the six-source vectored interrupt unit.
// Assumes one system clock and a synchronous active-high reset.
package irq_unit_pkg;
  // Request sources and slot numbering
  localparam int unsigned NUM_SRC = 6;
  localparam int unsigned SLOT_W = 3;
  localparam logic [2:0] req_slot_a = 3'h0; // Line two falling edge
  localparam logic [2:0] req_slot_b = 3'h1; // Line three falling edge
  localparam logic [2:0] req_slot_c = 3'h2; // Line one falling edge
  localparam logic [2:0] req_slot_d = 3'h3; // Line two rising edge
  localparam logic [2:0] req_slot_e = 3'h4; // Timer zero event
  localparam logic [2:0] req_slot_f = 3'h5; // Timer one event
  // Vector table geometry
  localparam int unsigned PMEM_ADDR_W = 16;
  localparam logic [15:0] VEC_TABLE_BASE = 16'h0000;
  localparam logic [15:0] VEC_BYTES_PER_SLOT = 16'h0002;
  // Register byte offsets
  localparam logic [3:0] OFS_REQ = 4'h0;
  localparam logic [3:0] OFS_MASK = 4'h4;
  localparam logic [3:0] OFS_PRIO = 4'h8;
  localparam logic [3:0] OFS_STAT = 4'hc;
  // Field positions
  localparam int unsigned MASK_GLOBAL_BIT = 7;
  localparam int unsigned STAT_SLOT_LSB = 0;
  localparam int unsigned STAT_BUSY_BIT = 3;
  localparam int unsigned STAT_GLOBAL_BIT = 4;
  // Reset values
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [2:0] PRIO_RESET = 3'h0;
  localparam logic [5:0] REQ_RESET = 6'h00;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Grant sequence states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SAVE,
    ST_FETCH_HI,
    ST_FETCH_LO,
    ST_JUMP
  } grant_state_t;
endpackage : irq_unit_pkg

// File: rtl/irq_vector_unit.sv
// Six-source vectored interrupt unit with AXI4-Lite register access.
// Assumes pins and timer events synchronous to clk_i; core saves state on request.
//
// Operation
// - Six sources, each maskable and prioritised
// - Falling edges of three port lines request
// - Rising edge of line two requests slot d
// - Timer zero and one request slots e, f
// - Mask register: global and per-source enables
// - Priority register orders the encoder
// - Each slot vectors through a byte pair
// - Grant disables further interrupts until re-enabled
// - Core saves counter and flags before branching
// - Handler address fetched from pair, then loaded
// - Masked requests still recorded for polling
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module irq_vector_unit (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic enable_i,
  // Request sources
  input wire logic port3_line_one_i,
  input wire logic port3_line_two_i,
  input wire logic port3_line_three_i,
  input wire logic timer_zero_event_i,
  input wire logic timer_one_event_i,
  // Core side
  output logic save_state_o,
  input wire logic save_done_i,
  output logic pmem_rd_o,
  output logic [irq_unit_pkg::PMEM_ADDR_W-1:0] pmem_addr_o,
  input wire logic [7:0] pmem_data_i,
  input wire logic pmem_valid_i,
  output logic handler_load_o,
  output logic [irq_unit_pkg::PMEM_ADDR_W-1:0] handler_addr_o,
  output logic [2:0] grant_slot_o,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);
  import irq_unit_pkg::*;

  // Byte address of one half of a slot's vector pair
  function automatic logic [15:0] vec_addr(input logic [2:0] slot, input logic low_half);
    vec_addr = VEC_TABLE_BASE + 16'(slot) * VEC_BYTES_PER_SLOT + 16'(low_half);
  endfunction : vec_addr

  // Known register offset
  function automatic logic mapped(input logic [3:0] addr);
    mapped = (addr == OFS_REQ) || (addr == OFS_MASK) || (addr == OFS_PRIO) || (addr == OFS_STAT);
  endfunction : mapped

  logic line_one_prev;
  logic line_two_prev;
  logic line_three_prev;
  logic primed;
  logic [5:0] events;
  logic [5:0] pending;
  logic [7:0] mask;
  logic [2:0] prio_start;
  logic global_en;
  logic [5:0] armed;
  logic found;
  logic [2:0] pick_slot;
  logic take;
  grant_state_t state;
  logic [7:0] vec_hi;
  logic [3:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;
  logic do_write;
  logic wr_req;
  logic wr_mask;
  logic wr_prio;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection

  // Previous pin levels; primed blocks a false edge on the first sample
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      line_one_prev <= 1'b1;
      line_two_prev <= 1'b1;
      line_three_prev <= 1'b1;
      primed <= 1'b0;
    end else if (enable_i) begin
      line_one_prev <= port3_line_one_i;
      line_two_prev <= port3_line_two_i;
      line_three_prev <= port3_line_three_i;
      primed <= 1'b1;
    end
  end

  // Per-slot event strobes
  always_comb begin
    events = 6'h00;
    events[req_slot_a] = primed && line_two_prev && !port3_line_two_i;
    events[req_slot_b] = primed && line_three_prev && !port3_line_three_i;
    events[req_slot_c] = primed && line_one_prev && !port3_line_one_i;
    events[req_slot_d] = primed && !line_two_prev && port3_line_two_i;
    events[req_slot_e] = timer_zero_event_i;
    events[req_slot_f] = timer_one_event_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request flags, mask and priority

  assign global_en = mask[MASK_GLOBAL_BIT];
  assign armed = pending & mask[5:0] & {6{global_en}};

  // Priority encoder steered by the priority register
  irq_priority_pick u_pick (
    .pending_i(armed),
    .start_i(prio_start),
    .found_o(found),
    .slot_o(pick_slot)
  );

  assign take = enable_i && (state == ST_IDLE) && found;

  // Flags set regardless of mask; a new event beats any clear
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pending <= REQ_RESET;
    end else if (enable_i) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (events[i]) begin
          pending[i] <= 1'b1;
        end else if ((take && pick_slot == 3'(i)) || (wr_req && w_byte[i])) begin
          pending[i] <= 1'b0;
        end
      end
    end
  end

  // Mask register; a grant drops the global enable
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mask <= MASK_RESET;
    end else if (enable_i) begin
      if (wr_mask) begin
        mask <= w_byte;
      end
      if (take) begin
        mask[MASK_GLOBAL_BIT] <= 1'b0;
      end
    end
  end

  // Priority start slot
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prio_start <= PRIO_RESET;
    end else if (enable_i && wr_prio) begin
      prio_start <= w_byte[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Grant sequence

  // Save request, two vector byte reads, then handler load
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= ST_IDLE;
      save_state_o <= 1'b0;
      pmem_rd_o <= 1'b0;
      pmem_addr_o <= VEC_TABLE_BASE;
      vec_hi <= 8'h00;
      handler_load_o <= 1'b0;
      handler_addr_o <= VEC_TABLE_BASE;
      grant_slot_o <= req_slot_a;
    end else if (enable_i) begin
      pmem_rd_o <= 1'b0;
      handler_load_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (found) begin
            grant_slot_o <= pick_slot;
            save_state_o <= 1'b1;
            state <= ST_SAVE;
          end
        end
        ST_SAVE: begin
          if (save_done_i) begin
            save_state_o <= 1'b0;
            pmem_addr_o <= vec_addr(grant_slot_o, 1'b0);
            pmem_rd_o <= 1'b1;
            state <= ST_FETCH_HI;
          end
        end
        ST_FETCH_HI: begin
          if (pmem_valid_i) begin
            vec_hi <= pmem_data_i;
            pmem_addr_o <= vec_addr(grant_slot_o, 1'b1);
            pmem_rd_o <= 1'b1;
            state <= ST_FETCH_LO;
          end
        end
        ST_FETCH_LO: begin
          if (pmem_valid_i) begin
            handler_addr_o <= {vec_hi, pmem_data_i};
            handler_load_o <= 1'b1;
            state <= ST_JUMP;
          end
        end
        ST_JUMP: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  assign do_write = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
  assign wr_req = do_write && w_lane0 && (aw_addr == OFS_REQ);
  assign wr_mask = do_write && w_lane0 && (aw_addr == OFS_MASK);
  assign wr_prio = do_write && w_lane0 && (aw_addr == OFS_PRIO);

  // Write address and data taken in either order, answered once both held
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
      aw_addr <= OFS_REQ;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (enable_i) begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_addr <= s_axi_awaddr_i; // Full offset kept so misaligned ones are refused
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_byte <= s_axi_wdata_i[7:0];
        w_lane0 <= s_axi_wstrb_i[0];
        s_axi_wready_o <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // Read channel; status shows grant state and last slot
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0;
      s_axi_rresp_o <= RESP_OKAY;
    end else if (enable_i) begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o <= RESP_OKAY;
        s_axi_rdata_o <= 32'h0;
        case (s_axi_araddr_i)
          OFS_REQ: s_axi_rdata_o[5:0] <= pending;
          OFS_MASK: s_axi_rdata_o[7:0] <= mask;
          OFS_PRIO: s_axi_rdata_o[2:0] <= prio_start;
          OFS_STAT: begin
            s_axi_rdata_o[STAT_SLOT_LSB +: 3] <= grant_slot_o;
            s_axi_rdata_o[STAT_BUSY_BIT] <= (state != ST_IDLE);
            s_axi_rdata_o[STAT_GLOBAL_BIT] <= global_en;
          end
          default: s_axi_rresp_o <= RESP_SLVERR;
        endcase
      end
      if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  fall_two_slot_a: assert property (@(posedge clk_i) disable iff (reset_i)
    enable_i && primed && line_two_prev && !port3_line_two_i |=> pending[req_slot_a])
    else $error("line two fall did not set slot a");

  rise_two_slot_a: assert property (@(posedge clk_i) disable iff (reset_i)
    enable_i && primed && !line_two_prev && port3_line_two_i |=> pending[req_slot_d] && !pending[req_slot_a] ||
    pending[req_slot_d])
    else $error("line two rise did not set slot d");

  timer_slot_a: assert property (@(posedge clk_i) disable iff (reset_i)
    enable_i && timer_one_event_i |=> pending[req_slot_f])
    else $error("timer one event did not set slot f");

  masked_record_a: assert property (@(posedge clk_i) disable iff (reset_i)
    enable_i && !global_en && primed && line_one_prev && !port3_line_one_i |=> pending[req_slot_c])
    else $error("masked line one fall not recorded");

  global_off_a: assert property (@(posedge clk_i) disable iff (reset_i)
    enable_i && state == ST_IDLE && !global_en |=> state == ST_IDLE)
    else $error("grant started while globally disabled");

  grant_disable_a: assert property (@(posedge clk_i) disable iff (reset_i)
    take |=> !global_en ##1 (state == ST_SAVE || !enable_i))
    else $error("grant left interrupts enabled");

  save_first_a: assert property (@(posedge clk_i) disable iff (reset_i)
    enable_i && state == ST_SAVE && !save_done_i |=> !pmem_rd_o && save_state_o)
    else $error("vector fetch before state save");

  vector_addr_a: assert property (@(posedge clk_i) disable iff (reset_i)
    enable_i && state == ST_SAVE && save_done_i |=> pmem_rd_o && pmem_addr_o == 16'(2 * grant_slot_o))
    else $error("wrong vector byte address");

  handler_load_a: assert property (@(posedge clk_i) disable iff (reset_i)
    enable_i && state == ST_FETCH_LO && pmem_valid_i |=>
    handler_load_o && handler_addr_o == {vec_hi, $past(pmem_data_i)})
    else $error("handler address not assembled from vector pair");

  sticky_req_a: assert property (@(posedge clk_i) disable iff (reset_i)
    enable_i && pending[req_slot_b] && !(take && pick_slot == req_slot_b) && !(wr_req && w_byte[req_slot_b])
    |=> pending[req_slot_b])
    else $error("request flag dropped without clear");
endmodule : irq_vector_unit
`default_nettype wire
